// ===== swl_host_model.sv
`timescale 1ns/10ps
module swl_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  // Link clock idles low between frames
  task automatic send(input logic [9:0] word, input int slow);
    cs_n_o = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      sdi_o = word[i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    #(62.5 + slow) cs_n_o = 1'b1;
    sdi_o = ~word[0];
  endtask
endmodule

// ===== swl_loader.sv
`timescale 1ns/10ps
// Functional notes
// - Serial data is sampled on every rising edge of the serial clock, the host keeping it valid there.
// - Bits shift in only while chip select is low, which the host holds for the whole word.
// - When chip select rises the address is decoded and the code goes only to the addressed wiper register.
// - Address 00 picks channel one, 01 channel two, 10 channel three and 11 channel four.
// - While midscale reset is low every wiper register is forced to 80 hex.
// - While power down is low every channel is shut down through the one SHUTDOWN_O output.
module swl_loader (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     SCLK_I,
  input  wire logic                     CS_N_I,
  input  wire logic                     SERIAL_IN_I,
  input  wire logic                     MIDSCALE_RESET_N_I,
  input  wire logic                     POWER_DOWN_N_I,
  output logic [swl_pkg::CODE_BITS-1:0] WIPER_ONE_O,
  output logic [swl_pkg::CODE_BITS-1:0] WIPER_TWO_O,
  output logic [swl_pkg::CODE_BITS-1:0] WIPER_THREE_O,
  output logic [swl_pkg::CODE_BITS-1:0] WIPER_FOUR_O,
  output logic                          SHUTDOWN_O,
  output logic                          LOAD_DONE_O
);
  import swl_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } swl_state_type;

  logic               sclk_s;
  logic               cs_n_s;
  logic               sdi_s;
  logic               mrst_n_s;
  logic               pdn_n_s;
  logic               sclk_prev_q;
  logic               cs_prev_q;
  logic               sclk_rise;
  logic               cs_rise;
  logic               cs_fall;
  swl_state_type      state_q;
  swl_state_type      state_d;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic [3:0]         cnt_q;
  logic [3:0]         cnt_d;
  logic [7:0]         wiper_q [NUM_CHAN];
  logic [7:0]         wiper_d [NUM_CHAN];
  logic               shut_q;
  logic               shut_d;
  logic               done_q;
  logic               done_d;

  swl_sync u_sclk (.clk_i(MCLK_I), .rst_i(RST_I), .async_i(SCLK_I),      .rst_val_i(1'b0), .sync_o(sclk_s));
  swl_sync u_cs   (.clk_i(MCLK_I), .rst_i(RST_I), .async_i(CS_N_I),      .rst_val_i(1'b1), .sync_o(cs_n_s));
  swl_sync u_sdi  (.clk_i(MCLK_I), .rst_i(RST_I), .async_i(SERIAL_IN_I), .rst_val_i(1'b0), .sync_o(sdi_s));
  swl_sync u_mrst (.clk_i(MCLK_I), .rst_i(RST_I), .async_i(MIDSCALE_RESET_N_I), .rst_val_i(1'b1),
                   .sync_o(mrst_n_s));
  swl_sync u_pdn  (.clk_i(MCLK_I), .rst_i(RST_I), .async_i(POWER_DOWN_N_I), .rst_val_i(1'b1),
                   .sync_o(pdn_n_s));

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign cs_rise   = cs_n_s & ~cs_prev_q;
  assign cs_fall   = ~cs_n_s & cs_prev_q;

  function automatic logic addr_hit(input logic [1:0] a, input int unsigned ch);
    unique case (a)
      ADDR_ONE:   addr_hit = (ch == 0);
      ADDR_TWO:   addr_hit = (ch == 1);
      ADDR_THREE: addr_hit = (ch == 2);
      ADDR_FOUR:  addr_hit = (ch == 3);
    endcase
  endfunction

  // Shift engine
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_SHIFT;
          cnt_d   = CNT_ZERO;
          if (sclk_rise) begin
            shift_d = {shift_q[WORD_BITS-2:0], sdi_s};
            cnt_d   = CNT_ONE;
          end
        end
      end
      ST_SHIFT: begin
        if (cs_n_s) begin
          state_d = ST_IDLE;
        end else if (sclk_rise) begin
          shift_d = {shift_q[WORD_BITS-2:0], sdi_s};
          if (cnt_q != CNT_FULL) begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
      end
    endcase
  end

  // Wiper latches, shutdown and load strobe
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      wiper_d[i] = wiper_q[i];
      if (!mrst_n_s) begin
        wiper_d[i] = MIDSCALE;
      end else if (cs_rise && addr_hit(shift_q[ADDR_MSB:ADDR_LSB], i)) begin
        wiper_d[i] = shift_q[CODE_MSB:0];
      end
    end
    shut_d = ~pdn_n_s;
    done_d = cs_rise & mrst_n_s;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_q     <= ST_IDLE;
      shift_q     <= '0;
      cnt_q       <= CNT_ZERO;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
      shut_q      <= 1'b0;
      done_q      <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        wiper_q[i] <= MIDSCALE;
      end
    end else begin
      state_q     <= state_d;
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
      shut_q      <= shut_d;
      done_q      <= done_d;
      for (int i = 0; i < NUM_CHAN; i++) begin
        wiper_q[i] <= wiper_d[i];
      end
    end
  end

  always_comb begin
    WIPER_ONE_O   = wiper_q[0];
    WIPER_TWO_O   = wiper_q[1];
    WIPER_THREE_O = wiper_q[2];
    WIPER_FOUR_O  = wiper_q[3];
    SHUTDOWN_O    = shut_q;
    LOAD_DONE_O   = done_q;
  end

  a_shift_on_edge: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == ST_SHIFT && !cs_n_s && sclk_rise) |=> shift_q == {$past(shift_q[WORD_BITS-2:0]), $past(sdi_s)})
    else $error("shift register did not take serial bit");
  a_hold_when_idle: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == ST_IDLE && !cs_fall) |=> $stable(shift_q))
    else $error("shift register moved while deselected");
  a_load_addressed: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_THREE) |=>
      wiper_q[2] == $past(shift_q[CODE_MSB:0]) && $stable(wiper_q[0]) && $stable(wiper_q[1]) && $stable(wiper_q[3]))
    else $error("wrong channel loaded");
  a_addr_one: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_ONE) |=>
      WIPER_ONE_O == $past(shift_q[CODE_MSB:0]))
    else $error("address 00 did not reach channel one");
  a_addr_four: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_FOUR) |=>
      WIPER_FOUR_O == $past(shift_q[CODE_MSB:0]))
    else $error("address 11 did not reach channel four");
  a_midscale_force: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !mrst_n_s |=> (WIPER_ONE_O == MIDSCALE && WIPER_TWO_O == MIDSCALE &&
                       WIPER_THREE_O == MIDSCALE && WIPER_FOUR_O == MIDSCALE))
    else $error("midscale reset not applied");
  a_shutdown_follow: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !pdn_n_s |=> SHUTDOWN_O)
    else $error("shutdown not asserted");
  a_shutdown_clear: assert property (@(posedge MCLK_I) disable iff (RST_I)
    pdn_n_s |=> !SHUTDOWN_O)
    else $error("shutdown stuck");
  a_done_pulse: assert property (@(posedge MCLK_I) disable iff (RST_I)
    LOAD_DONE_O |=> !LOAD_DONE_O)
    else $error("load strobe longer than one cycle");
  a_count_bound: assert property (@(posedge MCLK_I) disable iff (RST_I)
    cnt_q <= CNT_FULL)
    else $error("bit count overran word length");
  // Per-channel landing, select framing, counter and status pulse
  a_addr_two: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_TWO) |=>
      WIPER_TWO_O == $past(shift_q[CODE_MSB:0]))
    else $error("address 01 did not reach channel two");
  a_addr_three: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_THREE) |=>
      WIPER_THREE_O == $past(shift_q[CODE_MSB:0]))
    else $error("address 10 did not reach channel three");
  a_select_starts: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == ST_IDLE && cs_fall) |=> state_q == ST_SHIFT)
    else $error("falling select did not start a word");
  a_select_ends: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == ST_SHIFT && cs_n_s) |=> state_q == ST_IDLE)
    else $error("shifting went on after select rose");
  a_count_clear: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == ST_IDLE && cs_fall && !sclk_rise) |=> cnt_q == CNT_ZERO)
    else $error("bit count not cleared at word start");
  a_count_step: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (state_q == ST_SHIFT && !cs_n_s && sclk_rise && cnt_q != CNT_FULL) |=> cnt_q == $past(cnt_q) + CNT_ONE)
    else $error("bit count did not advance");
  a_done_on_load: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cs_rise && mrst_n_s) |=> LOAD_DONE_O)
    else $error("no load strobe after select rose");
  a_done_quiet: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !(cs_rise && mrst_n_s) |=> !LOAD_DONE_O)
    else $error("load strobe without a load");
  a_wiper_hold: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (!cs_rise && mrst_n_s) |=>
      $stable(WIPER_ONE_O) && $stable(WIPER_TWO_O) && $stable(WIPER_THREE_O) && $stable(WIPER_FOUR_O))
    else $error("wiper changed without a load");
  a_midscale_no_done: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !mrst_n_s |=> !LOAD_DONE_O)
    else $error("load strobe during midscale reset");

  c_full_word:  cover property (@(posedge MCLK_I) disable iff (RST_I) cs_rise && cnt_q == CNT_FULL);
  c_load_two:   cover property (@(posedge MCLK_I) disable iff (RST_I)
    cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_TWO);
  c_midscale:   cover property (@(posedge MCLK_I) disable iff (RST_I) !mrst_n_s ##1 mrst_n_s);
  c_shutdown:   cover property (@(posedge MCLK_I) disable iff (RST_I) SHUTDOWN_O ##1 !SHUTDOWN_O);
  c_load_four:  cover property (@(posedge MCLK_I) disable iff (RST_I)
    cs_rise && mrst_n_s && shift_q[ADDR_MSB:ADDR_LSB] == ADDR_FOUR);
endmodule

// ===== swl_pkg.sv
package swl_pkg;
  localparam int unsigned WORD_BITS   = 10;
  localparam int unsigned CODE_BITS   = 8;
  localparam int unsigned ADDR_BITS   = 2;
  localparam int unsigned NUM_CHAN    = 4;
  localparam logic [7:0]  MIDSCALE    = 8'h80;
  localparam logic [1:0]  ADDR_ONE    = 2'h0;
  localparam logic [1:0]  ADDR_TWO    = 2'h1;
  localparam logic [1:0]  ADDR_THREE  = 2'h2;
  localparam logic [1:0]  ADDR_FOUR   = 2'h3;
  localparam int unsigned ADDR_MSB    = 9;
  localparam int unsigned ADDR_LSB    = 8;
  localparam int unsigned CODE_MSB    = 7;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [3:0]  CNT_FULL    = 4'ha;
endpackage

// ===== swl_sync.sv
`timescale 1ns/10ps
module swl_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  input  wire logic rst_val_i,
  output logic      sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Reset value is a port only for the flops' synchronous reset, which is allowed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= rst_val_i;
      sync_o <= rst_val_i;
    end else begin
      meta_q <= meta_d;
      sync_o <= sync_d;
    end
  end
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import swl_pkg::*;
  localparam logic [7:0] CODES [4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};
  logic       mclk;
  logic       rst;
  logic       sclk;
  logic       cs_n;
  logic       serial_in;
  logic       mid_n;
  logic       pd_n;
  logic [7:0] wip_one;
  logic [7:0] wip_two;
  logic [7:0] wip_three;
  logic [7:0] wip_four;
  logic       shut;
  logic       done;
  logic [7:0] exp_w [4];
  int         error_cnt;
  int         samples_checked;
  swl_host_model i_swl_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_in));
  swl_loader i_swl_loader (
    .MCLK_I(mclk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .SERIAL_IN_I(serial_in),
    .MIDSCALE_RESET_N_I(mid_n), .POWER_DOWN_N_I(pd_n),
    .WIPER_ONE_O(wip_one), .WIPER_TWO_O(wip_two), .WIPER_THREE_O(wip_three), .WIPER_FOUR_O(wip_four),
    .SHUTDOWN_O(shut), .LOAD_DONE_O(done)
  );
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check_all();
    check("wiper_one", exp_w[0], wip_one);
    check("wiper_two", exp_w[1], wip_two);
    check("wiper_three", exp_w[2], wip_three);
    check("wiper_four", exp_w[3], wip_four);
  endtask
  // Sends one word and waits a bounded time for the load pulse
  task automatic load(input logic [1:0] a, input logic [7:0] c, input bit live, input int slow);
    bit seen;
    seen = 1'b0;
    i_swl_host_model.send({a, c}, slow);
    for (int n = 0; n < 12 && !seen; n++) begin
      @(negedge mclk);
      seen = (done === 1'b1);
    end
    check("load_done", {7'h0, live}, {7'h0, seen});
    if (live && !seen) results();
    if (live) exp_w[a] = c;
    check_all();
    repeat (2) @(negedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst = 1'b1;
    mid_n = 1'b1;
    pd_n = 1'b1;
    for (int i = 0; i < 4; i++) exp_w[i] = MIDSCALE;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    check_all();
    $display("test reset done");
    for (int i = 0; i < 4; i++) load(i[1:0], CODES[i], 1'b1, 0);
    for (int i = 0; i < 4; i++) load(2'h3 - i[1:0], ~CODES[i], 1'b1, 300);
    $display("test address map done");
    mid_n = 1'b0;
    repeat (5) @(negedge mclk);
    for (int i = 0; i < 4; i++) exp_w[i] = MIDSCALE;
    check_all();
    load(2'h1, 8'h33, 1'b0, 0);
    mid_n = 1'b1;
    repeat (5) @(negedge mclk);
    check_all();
    load(2'h2, 8'h7f, 1'b1, 0);
    $display("test midscale done");
    pd_n = 1'b0;
    repeat (5) @(negedge mclk);
    check("shutdown", 8'h01, {7'h0, shut});
    pd_n = 1'b1;
    repeat (5) @(negedge mclk);
    check("shutdown", 8'h00, {7'h0, shut});
    $display("test shutdown done");
    results();
  end
endmodule
